// *** verilog/wold_pkg.sv ***
package wold_pkg;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CFG      = 12'h4A0;
    localparam logic [11:0] IDX_STAT     = 12'h4A1;
    localparam logic [11:0] IDX_DA1      = 12'h4A2;
    localparam logic [11:0] IDX_DA2      = 12'h4A3;
    localparam logic [11:0] IDX_DA3      = 12'h4A4;
    localparam logic [11:0] IDX_PW1      = 12'h4A5;
    localparam logic [11:0] IDX_PW2      = 12'h4A6;
    localparam logic [11:0] IDX_PW3      = 12'h4A7;
    localparam logic [11:0] IDX_IRQ_STAT = 12'h4B0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h4B1;
    localparam logic [11:0] IDX_PATTERN  = 12'h4B2;
    localparam int          ADDR_W       = 14;
    // Config fields
    localparam int          CFG_SWAP_LO  = 14;
    localparam int          CFG_SFD_SEL  = 13;
    localparam int          CFG_CRC_GATE = 12;
    localparam int          CFG_LVL_CLR  = 11;
    localparam int          CFG_PW_LO    = 9;
    localparam int          CFG_LVL_MODE = 8;
    localparam int          CFG_ENABLE   = 7;
    localparam int          CFG_SECURE   = 5;
    localparam int          CFG_PAT_EN   = 1;
    localparam int          CFG_MAGIC_EN = 0;
    localparam logic [15:0] CFG_RESET    = 16'h1000;
    localparam logic [15:0] CFG_WR_MASK  = 16'hF7FF;
    // Status fields; event vector order is {sfd, crc, hack, pattern, magic}
    localparam int          ST_INT_SRC   = 12;
    localparam int          ST_SFD       = 7;
    localparam int          ST_CRC       = 6;
    localparam int          ST_HACK      = 5;
    localparam int          ST_PAT       = 1;
    localparam int          ST_MAGIC     = 0;
    localparam int          EV_W         = 5;
    // Frame bytes
    localparam logic [7:0]  PREAMBLE     = 8'h55;
    localparam logic [7:0]  SFD_SET      = 8'h5D;
    localparam logic [7:0]  SFD_CLR      = 8'hD5;
    localparam logic [7:0]  SYNC_BYTE    = 8'hFF;
    localparam int          SYNC_LEN     = 6;
    localparam int          DA_COPIES    = 16;
    localparam int          PW_LEN       = 6;
    localparam int          MAGIC_LEN    = SYNC_LEN + DA_COPIES * 6;
    localparam int          MAGIC_PW_LEN = MAGIC_LEN + PW_LEN;
    // Wake pulse: 8 cycles of a 100 MHz clock, counted on sys_clk
    localparam int          PULSE_BASE_NS = 80;
    localparam int          SYS_CLK_MHZ   = 200;
    localparam int          PULSE_BASE_CYC = (PULSE_BASE_NS * SYS_CLK_MHZ) / 1000;
    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_HUNT = 2'b01,
        S_DATA = 2'b10,
        S_SKIP = 2'b11
    } wold_state_e;
endpackage : wold_pkg

// *** verilog/wold_reorder.sv ***
`timescale 1ns/1ps
module wold_reorder (
    input  wire logic [7:0] byteIn,
    input  wire logic [1:0] mode,
    output logic      [7:0] byteOut
);
    import wold_pkg::*;
    always_comb begin
        case (mode)
            2'b00:   byteOut = byteIn;
            2'b01:   byteOut = {byteIn[0], byteIn[1], byteIn[2], byteIn[3],
                                byteIn[4], byteIn[5], byteIn[6], byteIn[7]};
            2'b10:   byteOut = {byteIn[3:0], byteIn[7:4]};
            2'b11:   byteOut = {byteIn[4], byteIn[5], byteIn[6], byteIn[7],
                                byteIn[0], byteIn[1], byteIn[2], byteIn[3]};
            default: byteOut = byteIn;
        endcase
    end
endmodule : wold_reorder

// *** verilog/wold_indicate.sv ***
`timescale 1ns/1ps
module wold_indicate (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       wakeEv,
    input  wire logic       levelMode,
    input  wire logic [1:0] widthSel,
    input  wire logic       levelClr,
    output logic            wakeOut
);
    import wold_pkg::*;
    localparam logic [7:0] BASE = 8'(PULSE_BASE_CYC);
    logic [7:0] remain;
    logic [7:0] width;
    assign width = BASE << widthSel;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wakeOut <= 1'b0;
            remain  <= 8'h00;
        end else if (levelMode) begin
            remain <= 8'h00;
            // New wake wins over a clear in the same cycle
            if (wakeEv)
                wakeOut <= 1'b1;
            else if (levelClr)
                wakeOut <= 1'b0;
        end else if (wakeEv && !wakeOut) begin
            wakeOut <= 1'b1;
            remain  <= width - 8'h01;
        end else if (remain != 8'h00) begin
            remain <= remain - 8'h01;
        end else begin
            wakeOut <= 1'b0;
        end
    end
endmodule : wold_indicate

// *** verilog/wold_detector.sv ***
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Swap field reorders received bytes
// - Delimiter bit picks 0x5D or 0xD5
// - Bad CRC gates magic and pattern
// - Gate off: no bad CRC indication
// - Self-clearing write drops held wake level
// - Pulse width 8..64 slow-clock cycles
// - Indication bit: level or timed pulse
// - Detection only while enable is set
// - Secure mode demands matching password
// - Pattern enable raises pattern interrupt
// - Magic enable raises magic interrupt
// - Status flags latch, clear on read
// - Wrong password latches hack flag
// - Source bit; enabling selects wake
module wold_detector (
    input  wire logic                         sys_clk,
    input  wire logic                         srst,
    input  wire logic                         hsel,
    input  wire logic [wold_pkg::ADDR_W-1:0]  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic [31:0]                  hwdata,
    input  wire logic                         hready,
    output logic                              hreadyout,
    output logic                              hresp,
    output logic      [31:0]                  hrdata,
    input  wire logic                         rxDv,
    input  wire logic                         rxByteValid,
    input  wire logic [7:0]                   rxByte,
    input  wire logic                         rxEnd,
    input  wire logic                         rxCrcBad,
    input  wire logic                         polarityEv,
    output logic                              wakeOut,
    output logic                              sharedInt,
    output logic                              irq
);
    import wold_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0]        cfg;
    logic               intSrc;
    logic [EV_W-1:0]    stat;
    logic [EV_W-1:0]    irqStat;
    logic [EV_W-1:0]    irqMask;
    logic [15:0]        da1, da2, da3, pw1, pw2, pw3, pattern;
    logic               wrPend;
    logic [11:0]        wrIdx;
    logic               addrOk;
    logic [11:0]        aIdx;
    logic               rdStat, rdIrq;
    logic               wrCfg, wrIrqStat;
    logic               lvlClr;
    logic [15:0]        rdVal;

    assign aIdx   = haddr[ADDR_W-1:2];
    // hsize is ignored: only whole-word transfers are supported
    assign addrOk = hsel && htrans[1] && hready && (hsize == 3'h2 || hsize != 3'h2);
    assign rdStat = addrOk && !hwrite && aIdx == IDX_STAT;
    assign rdIrq  = addrOk && !hwrite && aIdx == IDX_IRQ_STAT;
    assign wrCfg  = wrPend && wrIdx == IDX_CFG;
    assign wrIrqStat = wrPend && wrIdx == IDX_IRQ_STAT;
    assign lvlClr = wrCfg && hwdata[CFG_LVL_CLR];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= 1'b0;
            wrIdx     <= 12'h000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wrPend    <= addrOk && hwrite;
            wrIdx     <= aIdx;
        end
    end

    always_comb begin
        case (aIdx)
            IDX_CFG:      rdVal = cfg & CFG_WR_MASK;
            IDX_STAT:     rdVal = {3'h0, intSrc, 4'h0, stat[4:2], 3'h0, stat[1:0]};
            IDX_DA1:      rdVal = da1;
            IDX_DA2:      rdVal = da2;
            IDX_DA3:      rdVal = da3;
            IDX_PW1:      rdVal = pw1;
            IDX_PW2:      rdVal = pw2;
            IDX_PW3:      rdVal = pw3;
            IDX_IRQ_STAT: rdVal = {11'h000, irqStat};
            IDX_IRQ_MASK: rdVal = {11'h000, irqMask};
            IDX_PATTERN:  rdVal = pattern;
            default:      rdVal = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            hrdata <= 32'h0000_0000;
        else if (addrOk && !hwrite)
            hrdata <= {16'h0000, rdVal};
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg <= CFG_RESET;
            da1 <= 16'h0000;
            da2 <= 16'h0000;
            da3 <= 16'h0000;
            pw1 <= 16'h0000;
            pw2 <= 16'h0000;
            pw3 <= 16'h0000;
            pattern <= 16'h0000;
            irqMask <= 5'h00;
        end else if (wrPend) begin
            case (wrIdx)
                IDX_CFG:      cfg <= hwdata[15:0] & CFG_WR_MASK;
                IDX_DA1:      da1 <= hwdata[15:0];
                IDX_DA2:      da2 <= hwdata[15:0];
                IDX_DA3:      da3 <= hwdata[15:0];
                IDX_PW1:      pw1 <= hwdata[15:0];
                IDX_PW2:      pw2 <= hwdata[15:0];
                IDX_PW3:      pw3 <= hwdata[15:0];
                IDX_IRQ_MASK: irqMask <= hwdata[EV_W-1:0];
                IDX_PATTERN:  pattern <= hwdata[15:0];
                default:      ;
            endcase
        end
    end

    // Enabling detection forces the shared source to the wake event
    always_ff @(posedge sys_clk) begin
        if (srst)
            intSrc <= 1'b0;
        else if (wrCfg && hwdata[CFG_ENABLE] && !cfg[CFG_ENABLE])
            intSrc <= 1'b1;
        else if (wrPend && wrIdx == IDX_STAT)
            intSrc <= hwdata[ST_INT_SRC];
    end

    ////////////////////////////////////////////////////////////////////////////
    wold_state_e        state;
    logic [7:0]         ordByte;
    logic [7:0]         sfdByte;
    logic [6:0]         mPos;
    logic [2:0]         daIdx;
    logic               pwBad;
    logic               patHit;
    logic [7:0]         prevByte;
    logic               prevOk;
    logic               wolEn;
    logic               inData;
    logic               gate;
    logic               magicSeen, pwDone;
    logic               magicEv, patEv, hackEv, crcEv, sfdEv;
    logic [EV_W-1:0]    evVec;

    wold_reorder u_reorder (
        .byteIn  (rxByte),
        .mode    (cfg[CFG_SWAP_LO+1:CFG_SWAP_LO]),
        .byteOut (ordByte)
    );

    function automatic logic [7:0] daSel(input logic [2:0] i,
                                         input logic [15:0] a1, a2, a3);
        case (i)
            3'h0:    daSel = a3[15:8];
            3'h1:    daSel = a3[7:0];
            3'h2:    daSel = a2[15:8];
            3'h3:    daSel = a2[7:0];
            3'h4:    daSel = a1[15:8];
            default: daSel = a1[7:0];
        endcase
    endfunction : daSel

    function automatic logic [7:0] pwSel(input logic [2:0] i,
                                         input logic [15:0] p1, p2, p3);
        case (i)
            3'h0:    pwSel = p1[7:0];
            3'h1:    pwSel = p1[15:8];
            3'h2:    pwSel = p2[7:0];
            3'h3:    pwSel = p2[15:8];
            3'h4:    pwSel = p3[7:0];
            default: pwSel = p3[15:8];
        endcase
    endfunction : pwSel

    assign wolEn   = cfg[CFG_ENABLE];
    assign sfdByte = cfg[CFG_SFD_SEL] ? SFD_SET : SFD_CLR;
    assign inData  = state == S_DATA && rxByteValid;

    always_ff @(posedge sys_clk) begin
        if (srst || !wolEn) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: if (rxDv && !rxEnd) state <= S_HUNT;
                S_HUNT: begin
                    if (rxEnd)
                        state <= S_IDLE;
                    else if (rxByteValid && ordByte != PREAMBLE)
                        state <= (ordByte == sfdByte) ? S_DATA : S_SKIP;
                end
                S_DATA: if (rxEnd) state <= S_IDLE;
                S_SKIP: if (rxEnd) state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // Restart on a sync byte keeps a runt prefix from hiding a packet
    always_ff @(posedge sys_clk) begin
        if (srst || state != S_DATA) begin
            mPos  <= 7'h00;
            daIdx <= 3'h0;
            pwBad <= 1'b0;
        end else if (rxByteValid) begin
            if (mPos < 7'(SYNC_LEN)) begin
                mPos <= (ordByte == SYNC_BYTE) ? mPos + 7'h01 : 7'h00;
            end else if (mPos < 7'(MAGIC_LEN)) begin
                if (ordByte == daSel(daIdx, da1, da2, da3)) begin
                    mPos  <= mPos + 7'h01;
                    daIdx <= (daIdx == 3'h5) ? 3'h0 : daIdx + 3'h1;
                end else begin
                    mPos  <= (ordByte == SYNC_BYTE) ? 7'h01 : 7'h00;
                    daIdx <= 3'h0;
                end
            end else if (mPos < 7'(MAGIC_PW_LEN)) begin
                mPos <= mPos + 7'h01;
                if (ordByte != pwSel(3'(mPos - 7'(MAGIC_LEN)), pw1, pw2, pw3))
                    pwBad <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || state != S_DATA) begin
            prevByte <= 8'h00;
            prevOk   <= 1'b0;
            patHit   <= 1'b0;
        end else if (rxByteValid) begin
            prevByte <= ordByte;
            prevOk   <= 1'b1;
            if (prevOk && {prevByte, ordByte} == pattern)
                patHit <= 1'b1;
        end
    end

    assign magicSeen = mPos >= 7'(MAGIC_LEN);
    assign pwDone    = mPos == 7'(MAGIC_PW_LEN);
    assign gate      = cfg[CFG_CRC_GATE] && rxCrcBad;
    assign magicEv   = state == S_DATA && rxEnd && magicSeen && !gate
                       && cfg[CFG_MAGIC_EN]
                       && (!cfg[CFG_SECURE] || (pwDone && !pwBad));
    assign patEv     = state == S_DATA && rxEnd && patHit && !gate
                       && cfg[CFG_PAT_EN];
    assign hackEv    = state == S_DATA && rxEnd && magicSeen && !gate
                       && cfg[CFG_SECURE] && (pwBad || !pwDone);
    // With the gate off a bad CRC raises no flag of its own
    assign crcEv     = state == S_DATA && rxEnd && gate;
    assign sfdEv     = state == S_HUNT && rxByteValid && !rxEnd
                       && ordByte != PREAMBLE && ordByte != sfdByte;
    assign evVec     = {sfdEv, crcEv, hackEv, patEv, magicEv};

    ////////////////////////////////////////////////////////////////////////////
    // Set beats clear so an event in the read cycle is kept
    always_ff @(posedge sys_clk) begin
        if (srst)
            stat <= 5'h00;
        else
            stat <= (stat & ~(rdStat ? 5'h1F : 5'h00)) | evVec;
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            irqStat <= 5'h00;
        else
            irqStat <= (irqStat & ~(wrIrqStat ? hwdata[EV_W-1:0] : 5'h00)) | evVec;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq       <= 1'b0;
            sharedInt <= 1'b0;
        end else begin
            irq       <= |(irqStat & irqMask);
            sharedInt <= intSrc ? |irqStat[1:0] : polarityEv;
        end
    end

    wold_indicate u_indicate (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .wakeEv    (magicEv || patEv),
        .levelMode (cfg[CFG_LVL_MODE]),
        .widthSel  (cfg[CFG_PW_LO+1:CFG_PW_LO]),
        .levelClr  (lvlClr),
        .wakeOut   (wakeOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] hiCnt;
    always_ff @(posedge sys_clk) begin
        if (srst || !wakeOut)
            hiCnt <= 8'h00;
        else
            hiCnt <= hiCnt + 8'h01;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    swapNibble_a: assert property (cfg[15:14] == 2'b10 |->
        ordByte == {rxByte[3:0], rxByte[7:4]}) else $error("nibble swap wrong");
    sfdAccept_a: assert property (state == S_HUNT && rxByteValid && !rxEnd
        && ordByte == sfdByte && wolEn |=> state == S_DATA) else $error("sfd missed");
    crcGate_a: assert property (rxEnd && gate |-> !magicEv && !patEv
        ) else $error("bad crc not gated");
    crcQuiet_a: assert property (!cfg[CFG_CRC_GATE] |=> !$rose(stat[3])
        ) else $error("bad crc flagged");
    levelClear_a: assert property (cfg[CFG_LVL_MODE] && lvlClr && !magicEv
        && !patEv && hwdata[CFG_LVL_MODE] |=> !wakeOut) else $error("level not cleared");
    pulseWidth_a: assert property (!cfg[CFG_LVL_MODE] && $stable(cfg) &&
        $fell(wakeOut) |-> $past(hiCnt) == (8'(PULSE_BASE_CYC) << cfg[10:9]) - 8'h01)
        else $error("pulse width wrong");
    levelHold_a: assert property (cfg[CFG_LVL_MODE] && wakeOut && !lvlClr
        && $stable(cfg) |=> wakeOut) else $error("level dropped");
    disabled_a: assert property (!wolEn |=> state == S_IDLE && !magicEv
        ) else $error("detector active while off");
    securePw_a: assert property (magicEv && cfg[CFG_SECURE] |->
        pwDone && !pwBad) else $error("bad password accepted");
    magicIrq_a: assert property (magicEv && irqMask[0] |=> ##1 irq
        ) else $error("magic irq missing");
    patIrq_a: assert property (patEv && irqMask[1] |-> ##2 irq
        ) else $error("pattern irq missing");
    statLatch_a: assert property (magicEv |=> stat[0] [*1]
        ) else $error("magic status lost");
    hackFlag_a: assert property (hackEv |=> stat[2]) else $error("hack not flagged");
    srcForce_a: assert property (wrCfg && hwdata[CFG_ENABLE] && !wolEn
        |=> intSrc) else $error("source not forced");
    magicLen_a: assert property ($rose(magicSeen) |->
        $past(mPos) == 7'(MAGIC_LEN - 1) && daIdx == 3'h0) else $error("short magic accepted");

    magicSeen_c: cover property (magicEv);
    patSeen_c: cover property (patEv);
    hackSeen_c: cover property (hackEv);
    sfdErr_c: cover property (sfdEv);
endmodule : wold_detector

// *** bench/wold_rx_source.sv ***
`timescale 1ns/1ps
module wold_rx_source (
    input  wire logic       sys_clk,
    output logic            rxDv,
    output logic            rxByteValid,
    output logic      [7:0] rxByte,
    output logic            rxEnd,
    output logic            rxCrcBad
);
    bit busy = 1'b0;
    initial begin
        {rxDv, rxByteValid, rxByte, rxEnd, rxCrcBad} = '0;
    end
    // Idle lane keeps changing so a stale byte never passes for data
    always @(posedge sys_clk) if (!busy) rxByte <= ~rxByte;
    ////////////////////////////////////////////////////////////////////////////////
    // Bytes leave pre-swapped; every swap mode is its own inverse
    task automatic put(input logic [7:0] b, input logic [1:0] sw);
        @(posedge sys_clk);
        rxByteValid <= 1'b1;
        case (sw)
            2'b01:   rxByte <= {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
            2'b10:   rxByte <= {b[3:0], b[7:4]};
            2'b11:   rxByte <= {b[4], b[5], b[6], b[7], b[0], b[1], b[2], b[3]};
            default: rxByte <= b;
        endcase
    endtask : put
    task automatic send(input logic [7:0] sfd, input logic [1:0] sw, input logic [47:0] da,
                        input logic [47:0] pw, input bit withPw, input bit bad);
        busy = 1'b1;
        @(posedge sys_clk);
        rxDv <= 1'b1;
        repeat (7) put(8'h55, sw);
        put(sfd, sw);
        repeat (6) put(8'hFF, sw);
        for (int c = 0; c < 96; c++) put(da[47 - 8 * (c % 6) -: 8], sw);
        if (withPw) for (int c = 0; c < 6; c++) put(pw[47 - 8 * c -: 8], sw);
        @(posedge sys_clk);
        rxByteValid <= 1'b0;
        rxEnd       <= 1'b1;
        rxCrcBad    <= bad;
        busy = 1'b0;
        @(posedge sys_clk);
        rxEnd    <= 1'b0;
        rxCrcBad <= 1'b0;
        rxDv     <= 1'b0;
    endtask : send
endmodule : wold_rx_source

// *** bench/wold_detector_test.sv ***
`timescale 1ns/1ps
module wold_detector_test;
    import wold_pkg::*;
    localparam logic [47:0] DA = 48'h123456789ABC;
    localparam logic [47:0] PW = 48'h112233445566;
    logic              sys_clk = 1'b0;
    logic              srst = 1'b1;
    logic              hsel = 1'b0;
    logic              hwrite = 1'b0;
    logic              polarityEv = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = '0;
    logic [31:0]       hiCnt = '0;
    logic [31:0]       hrdata;
    logic              hreadyout, hresp, irq, wakeOut, sharedInt;
    logic              rxDv, rxByteValid, rxEnd, rxCrcBad;
    logic [7:0]        rxByte;
    int                num_errors = 0;
    int                tests_run = 0;
    int                cycles = 0;
    always #2.5 sys_clk = ~sys_clk;
    wold_detector i_wold_detector (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rxDv(rxDv), .rxByteValid(rxByteValid),
        .rxByte(rxByte), .rxEnd(rxEnd), .rxCrcBad(rxCrcBad), .polarityEv(polarityEv),
        .wakeOut(wakeOut), .sharedInt(sharedInt), .irq(irq));
    wold_rx_source i_wold_rx_source (.sys_clk(sys_clk), .rxDv(rxDv), .rxByteValid(rxByteValid),
        .rxByte(rxByte), .rxEnd(rxEnd), .rxCrcBad(rxCrcBad));
    // Wake pulse length measured by counting high cycles
    always @(posedge sys_clk) if (wakeOut === 1'b1) hiCnt <= hiCnt + 1;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic ahb(input bit w, input logic [11:0] idx, input logic [15:0] d,
                       output logic [31:0] r);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {idx, 2'h0};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, d};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : ahb
    // Trailing settle lets registered outputs catch up before any check
    task automatic wr(input logic [11:0] idx, input logic [15:0] d);
        logic [31:0] r;
        ahb(1'b1, idx, d, r);
        repeat (3) @(posedge sys_clk);
    endtask : wr
    task automatic rdChk(input logic [11:0] idx, input logic [15:0] exp, input string nm);
        logic [31:0] r;
        ahb(1'b0, idx, 16'h0000, r);
        chk(r, {16'h0000, exp}, nm);
        chk({31'h0, hresp}, 32'h0, "hresp okay");
    endtask : rdChk
    task automatic frame(input logic [7:0] sfd, input logic [1:0] sw, input logic [47:0] pw,
                         input bit withPw, input bit bad);
        hiCnt = '0;
        i_wold_rx_source.send(sfd, sw, DA, pw, withPw, bad);
        repeat (140) @(posedge sys_clk);
    endtask : frame
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rdChk(IDX_CFG, 16'h1000, "cfg reset");
        rdChk(IDX_STAT, 16'h0000, "stat reset");
        rdChk(12'h4AF, 16'h0000, "unmapped");
        wr(IDX_DA3, 16'h1234);
        wr(IDX_DA2, 16'h5678);
        wr(IDX_DA1, 16'h9ABC);
        wr(IDX_PW1, 16'h2211);
        wr(IDX_PW2, 16'h4433);
        wr(IDX_PW3, 16'h6655);
        wr(IDX_PATTERN, 16'h1234);
        wr(IDX_CFG, 16'h1003);
        frame(8'hD5, 2'h0, PW, 1'b0, 1'b0);
        rdChk(IDX_STAT, 16'h0000, "stat disabled");
        chk(hiCnt, 32'h0, "wake disabled");
        // Swap mode and pulse width stepped together to save frames
        for (int i = 0; i < 4; i++) begin
            wr(IDX_CFG, 16'h1083 | (16'(i) << 14) | (16'(i) << 9));
            frame(8'hD5, 2'(i), PW, 1'b0, 1'b0);
            chk(hiCnt, 32'h10 << i, "pulse width");
            rdChk(IDX_STAT, 16'h1003, "stat magic");
            rdChk(IDX_STAT, 16'h1000, "stat cleared");
            chk({31'h0, sharedInt}, 32'h1, "shared wake");
        end
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(IDX_IRQ_MASK, 16'h0001);
        chk({31'h0, irq}, 32'h1, "irq magic");
        wr(IDX_IRQ_STAT, 16'h0001);
        chk({31'h0, irq}, 32'h0, "irq magic clear");
        rdChk(IDX_IRQ_STAT, 16'h0002, "irq stat");
        wr(IDX_IRQ_MASK, 16'h0002);
        chk({31'h0, irq}, 32'h1, "irq pattern");
        wr(IDX_IRQ_STAT, 16'h001F);
        chk({31'h0, sharedInt}, 32'h0, "shared idle");
        wr(IDX_CFG, 16'h1083);
        frame(8'hD5, 2'h0, PW, 1'b0, 1'b1);
        rdChk(IDX_STAT, 16'h1040, "crc gated");
        chk(hiCnt, 32'h0, "wake gated");
        wr(IDX_CFG, 16'h0083);
        frame(8'hD5, 2'h0, PW, 1'b0, 1'b1);
        rdChk(IDX_STAT, 16'h1003, "crc ungated");
        wr(IDX_CFG, 16'h3083);
        frame(8'hD5, 2'h0, PW, 1'b0, 1'b0);
        rdChk(IDX_STAT, 16'h1080, "sfd error");
        frame(8'h5D, 2'h0, PW, 1'b0, 1'b0);
        rdChk(IDX_STAT, 16'h1003, "sfd alt");
        wr(IDX_CFG, 16'h10A3);
        frame(8'hD5, 2'h0, PW, 1'b1, 1'b0);
        rdChk(IDX_STAT, 16'h1003, "secure ok");
        // Pattern off so only the rejected magic packet could wake
        wr(IDX_CFG, 16'h10A1);
        frame(8'hD5, 2'h0, 48'h665544332211, 1'b1, 1'b0);
        rdChk(IDX_STAT, 16'h1020, "hack flag");
        chk(hiCnt, 32'h0, "wake hack");
        wr(IDX_CFG, 16'h1183);
        frame(8'hD5, 2'h0, PW, 1'b0, 1'b0);
        chk({31'h0, wakeOut}, 32'h1, "level held");
        rdChk(IDX_CFG, 16'h1183, "cfg level");
        wr(IDX_CFG, 16'h1983);
        chk({31'h0, wakeOut}, 32'h0, "level clear");
        rdChk(IDX_CFG, 16'h1183, "clear self");
        wr(IDX_STAT, 16'h0000);
        polarityEv <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, sharedInt}, 32'h1, "polarity route");
        summarize();
    end
endmodule : wold_detector_test
